/* File: ebc_pkg.sv */
package ebc_pkg;

    // Command code groups (upper nibble), low nibble selects the endpoint
    localparam logic [3:0] EBC_GRP_STALL = 4'h4;
    localparam logic [3:0] EBC_GRP_STAT_CLR = 4'h5;
    localparam logic [3:0] EBC_GRP_VALIDATE = 4'h6;
    localparam logic [3:0] EBC_GRP_CLEAR = 4'h7;
    localparam logic [3:0] EBC_GRP_UNSTALL = 4'h8;
    localparam logic [3:0] EBC_GRP_STAT_IMG = 4'hD;
    localparam logic [7:0] EBC_CMD_ACK_SETUP = 8'hF4;

    // Endpoint indices
    localparam logic [3:0] EBC_EP_CTRL_OUT = 4'h0;
    localparam logic [3:0] EBC_EP_CTRL_IN = 4'h1;
    localparam int EBC_NUM_EP = 16;

    // Status byte bit positions
    localparam int EBC_ST_HALT = 7;
    localparam int EBC_ST_FULL1 = 6;
    localparam int EBC_ST_FULL0 = 5;
    localparam int EBC_ST_TOGGLE = 4;
    localparam int EBC_ST_OVERRUN = 3;
    localparam int EBC_ST_SETUP = 2;
    localparam int EBC_ST_HOST_CPU_BUFFER_SELECT = 1;
    localparam logic [7:0] EBC_STATUS_RST = 8'h00;

    // Per-endpoint state
    typedef struct packed {
        logic endpoint_halted;
        logic secondary_buffer_full;
        logic primary_buffer_full;
        logic next_toggle;
        logic setup_overrun;
        logic setup_present;
        logic host_cpu_buffer_select;
        logic irq_pending;
    } ebc_ep_t;

    // Token / packet events from the serial engine, same clock
    typedef struct packed {
        logic setup_start;
        logic setup_done;
        logic out_done;
        logic in_done;
        logic toggle_next;
        logic [3:0] ep;
    } ebc_usb_ev_t;

    // Command port from the processor interface
    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } ebc_cmd_t;

endpackage

/* File: ebc_decode.sv */
`timescale 1ns/1ps
module ebc_decode
    import ebc_pkg::*;
(
    // Command in
    input wire logic [7:0] code,
    // Decoded strobes
    output logic is_stall,
    output logic is_unstall,
    output logic is_validate,
    output logic is_clear,
    output logic is_stat_img,
    output logic is_stat_clr,
    output logic is_ack_setup
);
    logic [3:0] grp;
    logic [3:0] ep;

    // Plain table decode; holes in ranges decode to nothing
    always_comb begin
        grp = code[7:4];
        ep = code[3:0];
        is_stall = (grp == EBC_GRP_STALL);
        is_unstall = (grp == EBC_GRP_UNSTALL);
        // Control OUT cannot be validated, control IN cannot be cleared
        is_validate = (grp == EBC_GRP_VALIDATE) && (ep != EBC_EP_CTRL_OUT);
        is_clear = (grp == EBC_GRP_CLEAR) && (ep != EBC_EP_CTRL_IN);
        is_stat_img = (grp == EBC_GRP_STAT_IMG);
        is_stat_clr = (grp == EBC_GRP_STAT_CLR);
        is_ack_setup = (code == EBC_CMD_ACK_SETUP);
    end
endmodule

/* File: ebc_cmd_unit.sv */
`timescale 1ns/1ps
// Functional notes
// - Codes 40h-4Fh set the halt flag of the selected endpoint.
// - Codes 80h-8Fh clear the halt flag of the selected endpoint.
// - SETUP token to a halted control endpoint clears its halt.
// - Leaving halt flushes buffers and resets toggle to DATA0.
// - Codes 61h-6Fh mark selected IN buffer full for next IN.
// - Validate and clear swap CPU buffer on double-buffered endpoints.
// - Codes 70h, 72h-7Fh empty the selected OUT buffer.
// - Received OUT packet sets full; once all buffers full, packets NAKed until clear.
// - Codes D0h-DFh return status copy, clearing only the overrun flag.
// - Status byte: 7 halt, 6/5 full flags, 4 toggle, all reset 0.
// - Bit 3 set on setup setup_overrun; read clears once storing done.
// - Bit 2 shows a setup packet is held.
// - Bit 1 shows CPU buffer: 0 primary, 1 secondary.
// - Setup arrival blocks validate and clear on control endpoints.
// - Codes 50h-5Fh read status and clear endpoint interrupt bit.
module ebc_cmd_unit
    import ebc_pkg::*;
#(
    parameter int NUM_EP = EBC_NUM_EP,
    parameter logic [NUM_EP-1:0] DOUBLE_BUF = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Processor command port
    input wire ebc_cmd_t cmd,
    // Serial engine events
    input wire ebc_usb_ev_t usb_ev,
    input wire logic irq_set,
    input wire logic [3:0] irq_ep,
    // Status answer
    output logic [7:0] status_data,
    output logic status_valid,
    // Per-endpoint views for the serial engine
    output logic [NUM_EP-1:0] ep_halted,
    output logic [NUM_EP-1:0] ep_nak,
    output logic [NUM_EP-1:0] ep_in_ready,
    output logic [NUM_EP-1:0] ep_irq,
    output logic setup_lock
);

    typedef struct packed {
        ebc_ep_t [NUM_EP-1:0] ep;
        logic setup_lock;
        logic [7:0] status_data;
        logic status_valid;
        logic [NUM_EP-1:0] halted;
        logic [NUM_EP-1:0] nak;
        logic [NUM_EP-1:0] in_ready;
        logic [NUM_EP-1:0] irq;
        logic [NUM_EP-1:0] storing; // Setup data still being written
    } ebc_state_t;

    ebc_state_t s_q;
    ebc_state_t s_d;
    logic is_stall, is_unstall, is_validate, is_clear;
    logic is_stat_img, is_stat_clr, is_ack_setup;

    ebc_decode u_dec (
        .code(cmd.code),
        .is_stall(is_stall),
        .is_unstall(is_unstall),
        .is_validate(is_validate),
        .is_clear(is_clear),
        .is_stat_img(is_stat_img),
        .is_stat_clr(is_stat_clr),
        .is_ack_setup(is_ack_setup)
    );

    // Status byte image of one endpoint, bit 0 reserved as zero
    function automatic logic [7:0] pack_status(input ebc_ep_t e);
        logic [7:0] b;
        b = EBC_STATUS_RST;
        b[EBC_ST_HALT] = e.endpoint_halted;
        b[EBC_ST_FULL1] = e.secondary_buffer_full;
        b[EBC_ST_FULL0] = e.primary_buffer_full;
        b[EBC_ST_TOGGLE] = e.next_toggle;
        b[EBC_ST_OVERRUN] = e.setup_overrun;
        b[EBC_ST_SETUP] = e.setup_present;
        b[EBC_ST_HOST_CPU_BUFFER_SELECT] = e.host_cpu_buffer_select;
        return b;
    endfunction

    // Flag raised by an engine event this cycle; a clear must not undo it
    function automatic logic fresh_set(input logic q, input logic d);
        return d && !q;
    endfunction

    // Flush an endpoint on leaving halt
    function automatic ebc_ep_t reinit(input ebc_ep_t e);
        ebc_ep_t r;
        r = e;
        r.endpoint_halted = 1'b0;
        r.primary_buffer_full = 1'b0;
        r.secondary_buffer_full = 1'b0;
        r.host_cpu_buffer_select = 1'b0;
        r.next_toggle = 1'b0; // DATA0 next, both directions
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        logic [3:0] sel;
        logic ctrl;
        logic full_now;
        s_d = s_q;
        sel = cmd.code[3:0];
        ctrl = (sel == EBC_EP_CTRL_OUT) || (sel == EBC_EP_CTRL_IN);
        full_now = 1'b0;
        s_d.status_valid = 1'b0;

        // Serial engine events; commands below win on the same endpoint, except over a buffer fill or interrupt raised this cycle
        if (usb_ev.setup_start) begin
            // Setup on a held, unacknowledged setup is an setup_overrun
            if (s_q.ep[usb_ev.ep].setup_present && s_q.setup_lock) begin
                s_d.ep[usb_ev.ep].setup_overrun = 1'b1;
            end
            if (s_q.ep[usb_ev.ep].endpoint_halted) begin
                s_d.ep[usb_ev.ep] = reinit(s_d.ep[usb_ev.ep]);
            end
            s_d.setup_lock = 1'b1;
            s_d.storing[usb_ev.ep] = 1'b1;
        end
        if (usb_ev.setup_done) begin
            s_d.storing[usb_ev.ep] = 1'b0;
            s_d.ep[usb_ev.ep].setup_present = 1'b1;
            s_d.ep[usb_ev.ep].primary_buffer_full = 1'b1;
            s_d.ep[usb_ev.ep].next_toggle = usb_ev.toggle_next;
        end
        if (usb_ev.out_done) begin
            // Fill the primary buffer, or the secondary one when the primary is full on a double-buffered endpoint
            if (DOUBLE_BUF[usb_ev.ep] && s_q.ep[usb_ev.ep].primary_buffer_full)
            begin
                s_d.ep[usb_ev.ep].secondary_buffer_full = 1'b1;
            end else begin
                s_d.ep[usb_ev.ep].primary_buffer_full = 1'b1;
            end
            s_d.ep[usb_ev.ep].next_toggle = usb_ev.toggle_next;
        end
        if (usb_ev.in_done) begin
            if (s_q.ep[usb_ev.ep].primary_buffer_full) begin
                s_d.ep[usb_ev.ep].primary_buffer_full = 1'b0;
            end else begin
                s_d.ep[usb_ev.ep].secondary_buffer_full = 1'b0;
            end
            s_d.ep[usb_ev.ep].next_toggle = usb_ev.toggle_next;
        end
        if (irq_set) begin
            s_d.ep[irq_ep].irq_pending = 1'b1;
        end

        // Processor commands
        if (cmd.valid) begin
            if (is_stall) begin
                s_d.ep[sel].endpoint_halted = 1'b1;
            end
            if (is_unstall && s_q.ep[sel].endpoint_halted) begin
                s_d.ep[sel] = reinit(s_d.ep[sel]);
            end else if (is_unstall) begin
                s_d.ep[sel].endpoint_halted = 1'b0;
            end
            // Control buffers frozen while setup unacknowledged
            if ((is_validate || is_clear) && !(ctrl && s_q.setup_lock)) begin
                full_now = is_validate;
                // A packet landing in this cycle survives the clear
                if (s_q.ep[sel].host_cpu_buffer_select) begin
                    s_d.ep[sel].secondary_buffer_full = full_now ||
                        fresh_set(s_q.ep[sel].secondary_buffer_full,
                        s_d.ep[sel].secondary_buffer_full);
                end else begin
                    s_d.ep[sel].primary_buffer_full = full_now ||
                        fresh_set(s_q.ep[sel].primary_buffer_full,
                        s_d.ep[sel].primary_buffer_full);
                end
                if (is_clear) begin
                    s_d.ep[sel].setup_present = 1'b0;
                end
                if (DOUBLE_BUF[sel]) begin
                    s_d.ep[sel].host_cpu_buffer_select =
                        ~s_q.ep[sel].host_cpu_buffer_select;
                end
            end
            if (is_stat_img || is_stat_clr) begin
                s_d.status_data = pack_status(s_q.ep[sel]);
                s_d.status_valid = 1'b1;
                // Overrun flag drops on read only when storing finished
                if (!s_d.storing[sel]) begin
                    s_d.ep[sel].setup_overrun = 1'b0;
                end
            end
            // A new interrupt in the same cycle survives the clear
            if (is_stat_clr && !(irq_set && irq_ep == sel)) begin
                s_d.ep[sel].irq_pending = 1'b0;
            end
            // A setup arriving with the acknowledge keeps the lock
            if (is_ack_setup && !usb_ev.setup_start) begin
                s_d.setup_lock = 1'b0;
            end
        end

        // Registered per-endpoint views for the engine
        for (int i = 0; i < NUM_EP; i++) begin
            s_d.halted[i] = s_d.ep[i].endpoint_halted;
            s_d.nak[i] = s_d.ep[i].primary_buffer_full &&
                (!DOUBLE_BUF[i] || s_d.ep[i].secondary_buffer_full);
            s_d.in_ready[i] = s_d.ep[i].primary_buffer_full ||
                s_d.ep[i].secondary_buffer_full;
            s_d.irq[i] = s_d.ep[i].irq_pending;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register, all flags clear at reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign status_data = s_q.status_data;
    assign status_valid = s_q.status_valid;
    assign ep_halted = s_q.halted;
    assign ep_nak = s_q.nak;
    assign ep_in_ready = s_q.in_ready;
    assign ep_irq = s_q.irq;
    assign setup_lock = s_q.setup_lock;

endmodule

/* File: ebc_cmd_unit_assertions.sv */
`timescale 1ns/1ps
module ebc_cmd_unit_chk
    import ebc_pkg::*;
#(
    parameter int NUM_EP = EBC_NUM_EP,
    parameter logic [NUM_EP-1:0] DOUBLE_BUF = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Unit inputs
    input wire ebc_cmd_t cmd,
    input wire ebc_usb_ev_t usb_ev,
    input wire logic irq_set,
    input wire logic [3:0] irq_ep,
    // Unit outputs
    input wire logic [7:0] status_data,
    input wire logic status_valid,
    input wire logic [NUM_EP-1:0] ep_halted,
    input wire logic [NUM_EP-1:0] ep_nak,
    input wire logic [NUM_EP-1:0] ep_in_ready,
    input wire logic [NUM_EP-1:0] ep_irq,
    input wire logic setup_lock
);
    logic [3:0] grp;
    logic [3:0] sel;
    logic go;
    logic ev0;
    // Command fields; ev0 is a setup token on the control OUT side
    assign grp = cmd.code[7:4];
    assign sel = cmd.code[3:0];
    assign go = cmd.valid;
    assign ev0 = usb_ev.setup_start && usb_ev.ep == 4'h0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////
    chk_stall_sets: assert property (
        go && grp == 4'h4 |=> ep_halted[$past(sel)]) else $error("no halt");
    chk_unstall_clears: assert property (
        go && grp == 4'h8 |=> !ep_halted[$past(sel)]) else $error("halted");
    chk_setup_unhalt: assert property (
        ev0 && !(go && cmd.code == 8'h40) |=> !ep_halted[0])
        else $error("setup left halt");
    chk_release_flush: assert property (
        go && grp == 4'h8 && ep_halted[sel]
        |=> !ep_nak[$past(sel)] && !ep_in_ready[$past(sel)])
        else $error("no flush");
    chk_validate_ready: assert property (
        go && grp == 4'h6 && sel > 4'h1 |=> ep_in_ready[$past(sel)])
        else $error("not ready");
    chk_clear_empties: assert property (
        go && grp == 4'h7 && sel > 4'h1
        && !(usb_ev.out_done && usb_ev.ep == sel) |=> !ep_nak[$past(sel)])
        else $error("still nak");
    chk_out_full_nak: assert property (
        usb_ev.out_done && usb_ev.ep > 4'h1 && !go && !ep_halted[usb_ev.ep]
        && !DOUBLE_BUF[usb_ev.ep] |=> ep_nak[$past(usb_ev.ep)])
        else $error("no nak");
    chk_status_answer: assert property (
        go && (grp == 4'h5 || grp == 4'hD) |=> status_valid && !status_data[0])
        else $error("bad status answer");
    chk_read_clears_irq: assert property (
        go && grp == 4'h5 && !(irq_set && irq_ep == sel)
        |=> !ep_irq[$past(sel)]) else $error("irq kept");
    chk_setup_locks: assert property (
        ev0 |=> setup_lock)
        else $error("no lock");
endmodule
bind ebc_cmd_unit ebc_cmd_unit_chk
    #(.NUM_EP(NUM_EP), .DOUBLE_BUF(DOUBLE_BUF)) u_chk (
    .clk, .rst_n, .cmd, .usb_ev, .irq_set, .irq_ep, .status_data,
    .status_valid,
    .ep_halted, .ep_nak, .ep_in_ready, .ep_irq, .setup_lock
);

/* File: ebc_cpu_model.sv */
`timescale 1ns/1ps
module ebc_cpu_model
    import ebc_pkg::*;
(
    // Clock
    input wire logic clk,
    // Command port
    output ebc_cmd_t cmd,
    // Status answer
    input wire logic [7:0] status_data
);
    initial cmd = '0;
    ////////////////////
    // One code a call, optional idle gap; outputs settled on return
    task automatic send(input logic [7:0] c, input int gap);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        cmd <= '{valid: 1'b1, code: c};
        @(posedge clk);
        cmd.valid <= 1'b0;
        #1;
    endtask
    // Acknowledge only if no newer setup overwrote the one in hand
    task automatic ack_setup(output logic done);
        send(8'hD0, 0);
        done = !status_data[EBC_ST_OVERRUN];
        if (done) send(EBC_CMD_ACK_SETUP, 0);
    endtask
endmodule

/* File: tb_endpoint_buffer_command_unit.sv */
`timescale 1ns/1ps
module tb_endpoint_buffer_command_unit
    import ebc_pkg::*;
;
    logic clk;
    logic rst_n;
    ebc_cmd_t cmd;
    ebc_usb_ev_t usb_ev;
    logic irq_set;
    logic [3:0] irq_ep;
    logic [7:0] status_data;
    logic status_valid;
    logic setup_lock;
    logic [15:0] ep_halted, ep_nak, ep_in_ready, ep_irq;
    logic [3:0] e;
    logic done;
    int seed = 32'hCA97;
    int num_errors = 0;
    int tests_run = 0;
    // Endpoint 2 double-buffered to reach the buffer swap
    ebc_cmd_unit #(.DOUBLE_BUF(16'h0004)) uut (
        .clk, .rst_n, .cmd, .usb_ev, .irq_set, .irq_ep, .status_data,
        .status_valid, .ep_halted, .ep_nak, .ep_in_ready, .ep_irq, .setup_lock
    );
    ebc_cpu_model cpu (.clk, .cmd, .status_data);
    always #4 clk = ~clk;
    ////////////////////
    task automatic finish_test;
        if (num_errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Status copy of one endpoint, taken as it stood before the read
    task automatic st(input logic [3:0] ep, input logic [7:0] exp);
        cpu.send({4'hD, ep}, 0);
        chk({8'h00, status_data}, {8'h00, exp});
    endtask
    // Serial engine event, one cycle wide
    task automatic ev(input ebc_usb_ev_t v);
        @(posedge clk);
        usb_ev <= v;
        @(posedge clk);
        usb_ev <= '0;
        #1;
    endtask
    // Watchdog, far above the run length
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        finish_test;
    end
    ////////////////////
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        usb_ev = '0;
        irq_set = 1'b0;
        irq_ep = 4'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 16; i++) st(4'(i), 8'h00);
        // Random halt and release on 20 randomly picked endpoints
        repeat (20) begin
            e = 4'($random(seed));
            cpu.send({4'h4, e}, int'(e[1:0]));
            chk(ep_halted, 16'h1 << e);
            st(e, 8'h80);
            cpu.send({4'h8, e}, 0);
            chk(ep_halted, 16'h0000);
        end
        // Packet fills and NAKs; release from halt flushes it
        ev({5'b00101, 4'h3});
        chk(ep_nak, 16'h0008);
        st(4'h3, 8'h30);
        cpu.send(8'h43, 0);
        cpu.send(8'h83, 1);
        st(4'h3, 8'h00);
        ev({5'b00100, 4'h4});
        cpu.send(8'h74, 0);
        chk(ep_nak, 16'h0000);
        cpu.send(8'h65, 2);
        chk(ep_in_ready, 16'h0020);
        // IN sent empties the buffer and stores the DATA1 toggle
        ev({5'b00011, 4'h5});
        st(4'h5, 8'h10);
        cpu.send(8'h62, 0);
        st(4'h2, 8'h22);
        cpu.send(8'h62, 0);
        st(4'h2, 8'h60);
        // Setup on a halted control endpoint, re-halt, then setup_overrun
        cpu.send(8'h40, 0);
        ev({5'b10000, 4'h0});
        chk({ep_halted[0], setup_lock}, 16'h0001);
        cpu.send(8'h40, 0);
        ev({5'b01000, 4'h0});
        st(4'h0, 8'hA4);
        cpu.send(8'h61, 0);
        chk({15'h0, ep_in_ready[1]}, 16'h0000);
        ev({5'b10000, 4'h0});
        ev({5'b01000, 4'h0});
        st(4'h0, 8'h2C);
        st(4'h0, 8'h24);
        cpu.ack_setup(done);
        chk({done, setup_lock}, 16'h0002);
        cpu.send(8'h61, 0);
        chk({15'h0, ep_in_ready[1]}, 16'h0001);
        // Clear on control IN is no command at all
        cpu.send(8'h71, 0);
        chk({15'h0, ep_in_ready[1]}, 16'h0001);
        // Image read keeps the interrupt, clearing read drops it
        @(posedge clk);
        irq_ep <= 4'h6;
        irq_set <= 1'b1;
        @(posedge clk);
        irq_set <= 1'b0;
        cpu.send(8'hD6, 0);
        chk(ep_irq, 16'h0040);
        cpu.send(8'h56, 0);
        chk({ep_irq[6], status_valid}, 16'h0001);
        finish_test;
    end
endmodule
